// ### logic/embd_params.svh
// Offsets, field positions, reset values and address bounds of the bus front end
`ifndef EMBD_PARAMS_SVH
`define EMBD_PARAMS_SVH
`define EMBD_WAIT_CONTROL_IDX 12'h0a7
`define EMBD_CONFIG_IDX 12'h0a8
`define EMBD_STATUS_IDX 12'h0a9
`define EMBD_WAIT_CONTROL_RST 8'h00
`define EMBD_CONFIG_RST 16'h0000
`define EMBD_WIE_BIT 0
`define EMBD_WCE_BIT 1
`define EMBD_MSS_LSB 0
`define EMBD_PAGE_BIT 2
`define EMBD_MIRROR_N_BIT 3
`define EMBD_ROM_LSB 4
`define EMBD_RAM1K_BIT 6
`define EMBD_WS_LSB 8
`define EMBD_REGFILE_TOP 24'h00001f
`define EMBD_BITRAM_TOP 24'h00007f
`define EMBD_RAM512_TOP 24'h00021f
`define EMBD_RAM1K_TOP 24'h00041f
`define EMBD_MIRROR_BASE 24'h00e000
`define EMBD_SEG_TOP 24'h00ffff
`define EMBD_LEGACY_TOP 24'h7fffff
`define EMBD_EXT1_TOP 24'h01ffff
`define EMBD_RSVD_TOP 24'hfdffff
`define EMBD_CODE8K_TOP 24'hff1fff
`define EMBD_CODE16K_TOP 24'hff3fff
`define EMBD_FF_BASE 24'hff0000
`define EMBD_CFG_ARRAY_BASE 24'hfffff8
`define EMBD_MIRROR_TARGET 24'hff2000
`endif

// ### logic/embd_pkg.sv
// Types shared by the external memory bus front end
package embd_pkg;
	typedef enum logic [2:0] {MD_DIRECT, MD_INDIRECT, MD_REGISTER, MD_BIT, MD_FETCH} embd_mode_e;
	typedef enum logic [2:0] {RG_REGFILE, RG_RAM, RG_EXT, RG_CODE, RG_RSVD, RG_CFG, RG_SFR}
		embd_region_e;
	typedef enum logic [1:0] {ROM_NONE, ROM_8K, ROM_16K, ROM_SPARE} embd_rom_e;
	typedef struct packed {
		logic [23:0] addr;
		logic write;
		logic sfr;
		embd_mode_e mode;
		logic [7:0] wdata;
	} embd_req_s;
	typedef struct packed {
		embd_region_e region;
		logic [23:0] addr;
		logic [7:0] rdata;
		logic illegal;
		logic undefined;
	} embd_rsp_s;
endpackage

// ### logic/embd_bus.sv
// External memory bus front end: address decode, strobes, waits, wait clock
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "embd_params.svh"
module embd_bus (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire embd_pkg::embd_req_s req,
	input wire logic req_valid,
	output logic req_ready,
	output embd_pkg::embd_rsp_s rsp,
	output logic rsp_valid,
	output logic boot_internal,
	input wire logic external_access_select_n,
	input wire logic wait_n,
	input wire logic gpio_p17,
	input wire logic gpio_p37,
	output logic p1_7_out,
	output logic p3_7_out,
	output logic program_store_strobe_n,
	output logic write_strobe_n,
	output logic addr_latch,
	output logic [7:0] p0_out,
	output logic p0_oe,
	input wire logic [7:0] p0_in,
	output logic [7:0] p2_out,
	output logic p2_oe,
	input wire logic [7:0] p2_in
);
	import embd_pkg::*;
	typedef enum logic [1:0] {BS_IDLE, BS_ADDR, BS_DATA, BS_DONE} embd_state_e;

	// Index times four still fits the 12-bit register bus
	localparam logic [11:0] WAIT_CONTROL_ADDR = `EMBD_WAIT_CONTROL_IDX << 2;
	localparam logic [11:0] CONFIG_ADDR = `EMBD_CONFIG_IDX << 2;
	localparam logic [11:0] STATUS_ADDR = `EMBD_STATUS_IDX << 2;

	logic [7:0] wait_control_r;
	logic [15:0] config_r;
	embd_state_e state_r;
	embd_req_s cur_r;
	embd_rsp_s rsp_r;
	logic [1:0] ws_cnt_r;
	logic wclk_r;
	logic program_store_strobe_n_k_r, rd_k_r, wr_k_r;
	logic ea_r, started_r;
	logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [11:0] aw_addr_r;
	logic [31:0] w_data_r, rdata_r;
	logic [3:0] w_strb_r;
	logic [1:0] bresp_r, rresp_r;

	wire logic wie = wait_control_r[`EMBD_WIE_BIT];
	wire logic wce = wait_control_r[`EMBD_WCE_BIT];
	wire logic [1:0] mss = config_r[`EMBD_MSS_LSB +: 2];
	wire logic page_mode = config_r[`EMBD_PAGE_BIT];
	wire logic code_mirror_map_n = config_r[`EMBD_MIRROR_N_BIT];
	wire embd_rom_e rom = embd_rom_e'(config_r[`EMBD_ROM_LSB +: 2]);
	wire logic ram_1k = config_r[`EMBD_RAM1K_BIT];
	wire logic [1:0] prog_ws = config_r[`EMBD_WS_LSB +: 2];

	// Region decode of a 24-bit internal address
	function automatic embd_region_e decode(input logic [23:0] a, input logic wr,
		input logic sfr, input logic ea);
		logic [23:0] ram_top;
		ram_top = ram_1k ? `EMBD_RAM1K_TOP : `EMBD_RAM512_TOP;
		if (sfr)
			return RG_SFR;
		if (a <= `EMBD_REGFILE_TOP)
			return RG_REGFILE;
		if (a <= ram_top)
			return RG_RAM;
		if (a <= `EMBD_RAM1K_TOP)
			return RG_RSVD;
		if (a >= `EMBD_MIRROR_BASE && a <= `EMBD_SEG_TOP)
			return (rom == ROM_16K && !code_mirror_map_n && ea && !wr) ? RG_CODE : RG_EXT;
		if (a <= `EMBD_EXT1_TOP)
			return RG_EXT;
		if (a <= `EMBD_RSVD_TOP)
			return RG_RSVD;
		if (a >= `EMBD_CFG_ARRAY_BASE)
			return RG_CFG;
		if (a >= `EMBD_FF_BASE && ((rom == ROM_8K && a <= `EMBD_CODE8K_TOP) ||
			(rom == ROM_16K && a <= `EMBD_CODE16K_TOP)))
			return RG_CODE;
		return RG_EXT;
	endfunction

	// Addressing mode allowed for an address
	function automatic logic mode_ok(input logic [23:0] a, input embd_mode_e m);
		if (m == MD_FETCH)
			return 1'b1;
		if (a > `EMBD_SEG_TOP)
			return m == MD_INDIRECT;
		if (m == MD_BIT)
			return a > `EMBD_REGFILE_TOP && a <= `EMBD_BITRAM_TOP;
		if (m == MD_REGISTER)
			return a <= `EMBD_REGFILE_TOP;
		return 1'b1;
	endfunction

	wire embd_region_e req_region = decode(req.addr, req.write, req.sfr, ea_r);
	wire logic req_legal = mode_ok(req.addr, req.mode) && req_region != RG_CFG;
	wire logic req_ext = req_legal && req_region == RG_EXT;
	wire logic accept = req_valid && req_ready;
	wire logic legacy = req.addr <= `EMBD_SEG_TOP;
	// mirror lands in upper code half
	wire logic mirrored = req_region == RG_CODE && legacy;
	wire logic [23:0] rsp_addr = mirrored ?
		req.addr - `EMBD_MIRROR_BASE + `EMBD_MIRROR_TARGET : req.addr;
	wire logic k_program_store_strobe_n = !req.write && (mss != 2'b11 || req.addr > `EMBD_LEGACY_TOP);
	wire logic k_rd = !req.write && mss == 2'b11 && req.addr <= `EMBD_LEGACY_TOP;
	wire logic k_wr = req.write && (mss != 2'b11 || legacy);
	wire logic stall = wie && !wait_n;
	wire logic data_end = state_r == BS_DATA && ws_cnt_r == 2'd0 && !stall;
	wire logic [7:0] read_byte = page_mode ? p2_in : p0_in;

	assign req_ready = state_r == BS_IDLE && started_r;
	assign rsp = rsp_r;
	assign rsp_valid = state_r == BS_DONE;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= BS_IDLE;
			cur_r <= '0;
			rsp_r <= '0;
			ws_cnt_r <= 2'd0;
			program_store_strobe_n_k_r <= 1'b0;
			rd_k_r <= 1'b0;
			wr_k_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				BS_IDLE:
				begin
					if (accept)
					begin
						cur_r <= req;
						program_store_strobe_n_k_r <= k_program_store_strobe_n;
						rd_k_r <= k_rd;
						wr_k_r <= k_wr;
						ws_cnt_r <= prog_ws;
						rsp_r <= '{req_region, rsp_addr, 8'h00, !req_legal,
							req_region == RG_RSVD};
						state_r <= req_ext ? BS_ADDR : BS_DONE;
					end
				end
				BS_ADDR:
					state_r <= BS_DATA;
				BS_DATA:
				begin
					if (ws_cnt_r != 2'd0)
						ws_cnt_r <= ws_cnt_r - 2'd1;
					if (data_end)
					begin
						rsp_r.rdata <= cur_r.write ? 8'h00 : read_byte;
						state_r <= BS_DONE;
					end
				end
				BS_DONE:
					state_r <= BS_IDLE;
				default:
					state_r <= BS_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			started_r <= 1'b0;
			ea_r <= 1'b0;
		end
		else if (!started_r)
		begin
			started_r <= 1'b1;
			ea_r <= external_access_select_n;
		end
	end
	assign boot_internal = started_r && ea_r && rom != ROM_NONE;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || !wce)
			wclk_r <= 1'b0;
		else
			wclk_r <= !wclk_r;
	end

	wire logic in_data = state_r == BS_DATA;
	wire logic in_cycle = state_r == BS_ADDR || in_data;
	assign addr_latch = state_r == BS_ADDR;
	assign program_store_strobe_n = !(in_data && program_store_strobe_n_k_r);
	assign write_strobe_n = !(in_data && wr_k_r);
	// port 1 bit 7 carries A17 when mss is 00, else the wait clock when wce is set, else gpio_p17
	assign p1_7_out = mss == 2'b00 ? (cur_r.addr[17] && in_cycle) : (wce ? wclk_r : gpio_p17);
	assign p3_7_out = mss == 2'b11 ? !(in_data && rd_k_r) :
		(mss == 2'b10 ? gpio_p37 : (cur_r.addr[16] && in_cycle));
	assign p0_out = (page_mode || !in_data) ? cur_r.addr[7:0] : cur_r.wdata;
	assign p0_oe = in_cycle && (page_mode || !in_data || cur_r.write);
	assign p2_out = (page_mode && in_data) ? cur_r.wdata : cur_r.addr[15:8];
	assign p2_oe = in_cycle && (!page_mode || !in_data || cur_r.write);

	// Register slave: one write and one read at a time
	wire logic aw_take = s_axi_awvalid && s_axi_awready;
	wire logic w_take = s_axi_wvalid && s_axi_wready;
	wire logic do_write = aw_hold_r && w_hold_r && !bvalid_r;
	wire logic [11:0] wr_addr = {aw_addr_r[11:2], 2'b00};
	wire logic [11:0] rd_addr = {s_axi_araddr[11:2], 2'b00};
	wire logic wr_mapped = wr_addr == WAIT_CONTROL_ADDR || wr_addr == CONFIG_ADDR ||
		wr_addr == STATUS_ADDR;
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'b00;
			aw_addr_r <= 12'h000;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			wait_control_r <= `EMBD_WAIT_CONTROL_RST;
			config_r <= `EMBD_CONFIG_RST;
		end
		else
		begin
			if (aw_take)
			begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_mapped ? 2'b00 : 2'b10;
				if (wr_addr == WAIT_CONTROL_ADDR && w_strb_r[0])
					wait_control_r <= w_data_r[7:0];
				if (wr_addr == CONFIG_ADDR && w_strb_r[0])
					config_r[7:0] <= w_data_r[7:0];
				if (wr_addr == CONFIG_ADDR && w_strb_r[1])
					config_r[15:8] <= w_data_r[15:8];
			end
			else if (bvalid_r && s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= 2'b00;
			if (rd_addr == WAIT_CONTROL_ADDR)
				rdata_r <= {24'h000000, wait_control_r};
			else if (rd_addr == CONFIG_ADDR)
				rdata_r <= {16'h0000, config_r};
			else if (rd_addr == STATUS_ADDR)
				rdata_r <= {26'h0000000, ea_r, wclk_r, wait_n, state_r != BS_IDLE, state_r};
			else
			begin
				rdata_r <= 32'h0000_0000;
				rresp_r <= 2'b10;
			end
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_r <= 1'b0;
	end

	sequence s_ext_start;
		accept && req_ext;
	endsequence
	sequence s_addr_then_data;
		addr_latch ##1 in_data;
	endsequence

	a_cycle_shape: assert property (@(posedge aclk) disable iff (!aresetn)
		s_ext_start |=> s_addr_then_data)
		else $error("external cycle did not go address then data");
	a_wait_stretch: assert property (@(posedge aclk) disable iff (!aresetn)
		in_data && ws_cnt_r == 2'd0 && wie && !wait_n |=> in_data && !rsp_valid)
		else $error("cycle ended while wait held low");
	a_wait_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		in_data && ws_cnt_r == 2'd0 && !wie |=> rsp_valid)
		else $error("disabled wait input stretched the cycle");
	a_wclk_square: assert property (@(posedge aclk) disable iff (!aresetn)
		wce [*3] |-> wclk_r != $past(wclk_r) && wclk_r == $past(wclk_r, 2))
		else $error("wait clock is not a half-rate square wave");
	a_wclk_on_pin: assert property (@(posedge aclk) disable iff (!aresetn)
		mss != 2'b00 && wce |-> p1_7_out == wclk_r)
		else $error("wait clock missing on port 1 bit 7");
	a_page_ports: assert property (@(posedge aclk) disable iff (!aresetn)
		page_mode && in_data && cur_r.write |-> p0_out == cur_r.addr[7:0] &&
		p2_out == cur_r.wdata && p2_oe)
		else $error("page mode port use wrong");
	a_legacy_rd: assert property (@(posedge aclk) disable iff (!aresetn)
		mss == 2'b11 && in_data && !cur_r.write && cur_r.addr <= `EMBD_LEGACY_TOP |->
		!p3_7_out && program_store_strobe_n)
		else $error("read strobe split wrong");
	a_no_cfg_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
		accept && req_region == RG_CFG |=> rsp_valid && rsp.illegal)
		else $error("configuration array reached the bus");
	a_rsvd_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		accept && req_region == RG_RSVD |=> rsp_valid && rsp.undefined && !addr_latch)
		else $error("reserved access started a cycle");
	a_a17_driven: assert property (@(posedge aclk) disable iff (!aresetn)
		mss == 2'b00 && in_cycle |-> p1_7_out == cur_r.addr[17])
		else $error("A17 not driven for widest select");
endmodule

// ### verification/embd_ext_mem.sv
// External code/data memory with real-time ready logic
`timescale 1ns/1ps
module embd_ext_mem (
	input wire logic aclk,
	input wire logic page,
	input wire logic [7:0] stall,
	input wire logic addr_latch,
	input wire logic [7:0] p0_out,
	input wire logic [7:0] p2_out,
	input wire logic program_store_strobe_n_n,
	input wire logic rd_n,
	input wire logic wr_n,
	output logic [7:0] p0_in,
	output logic [7:0] p2_in,
	output logic wait_n
);
	logic [15:0] adr_r = 16'h0000;
	logic [7:0] cnt_r = 8'h00;
	logic [7:0] p0_last_r = 8'h00;
	logic [7:0] p2_last_r = 8'h00;
	wire rd_act = !program_store_strobe_n_n || !rd_n;
	wire cyc = rd_act || !wr_n;
	wire [7:0] dat = adr_r[7:0] ^ adr_r[15:8];
	always @(posedge aclk)
	begin
		if (addr_latch)
			adr_r <= {p2_out, p0_out};
		cnt_r <= cyc ? cnt_r + 8'h01 : 8'h00;
		p0_last_r <= p0_in;
		p2_last_r <= p2_in;
	end
	assign wait_n = !(cyc && cnt_r < stall);
	// Released lanes toggle so a stale sample never matches
	assign p0_in = (rd_act && !page) ? dat : ~p0_last_r;
	assign p2_in = (rd_act && page) ? dat : ~p2_last_r;
endmodule

// ### verification/ext_memory_bus_decode_tb_top.sv
// Self-checking bench for the external memory bus front end
`timescale 1ns/1ps
module ext_memory_bus_decode_tb_top;
	import embd_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic req_valid, req_ready, rsp_valid, boot_internal, external_access_select_n, wait_n;
	logic gpio_p17, gpio_p37, p1_7_out, p3_7_out, program_store_strobe_n, write_strobe_n;
	logic addr_latch, p0_oe, p2_oe, sel11, page, ps_seen, rd_seen, wr_seen, prev;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, cap, oe_cap;
	logic [7:0] p0_out, p0_in, p2_out, p2_in, stall, wdat;
	embd_req_s req;
	embd_rsp_s rsp;
	int mismatches, samples_checked, lat;
	embd_bus dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .req, .req_valid, .req_ready, .rsp, .rsp_valid, .boot_internal,
		.external_access_select_n, .wait_n, .gpio_p17, .gpio_p37, .p1_7_out, .p3_7_out,
		.program_store_strobe_n, .write_strobe_n, .addr_latch, .p0_out, .p0_oe, .p0_in,
		.p2_out, .p2_oe, .p2_in);
	embd_ext_mem mem (.aclk, .page, .stall, .addr_latch, .p0_out, .p2_out,
		.program_store_strobe_n_n(program_store_strobe_n), .rd_n(sel11 ? p3_7_out : 1'h1),
		.wr_n(write_strobe_n), .p0_in, .p2_in, .wait_n);
	initial
	begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end
	// Strobe history per request, pin state at address phase
	always @(posedge aclk)
	begin
		if (addr_latch)
			cap <= {p1_7_out, p3_7_out};
		if (!program_store_strobe_n || !write_strobe_n)
			oe_cap <= {p0_oe, p2_oe};
		if (!write_strobe_n)
			wdat <= page ? p2_out : p0_out;
		if (req_valid && req_ready)
			{ps_seen, rd_seen, wr_seen} <= 3'h0;
		else
			{ps_seen, rd_seen, wr_seen} <= {ps_seen | !program_store_strobe_n,
				rd_seen | !p3_7_out, wr_seen | !write_strobe_n};
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1);
		rr = s_axi_bresp;
	endtask
	task automatic axr(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	task automatic cfg(input logic [15:0] v);
		axw(12'h2a0, {16'h0000, v});
	endtask
	task automatic acc(input logic [23:0] a, input logic w, input logic s, input embd_mode_e m);
		req <= '{a, w, s, m, 8'h3c};
		req_valid <= 1'h1;
		do
		begin
			@(posedge aclk);
		end
		while (req_ready !== 1'h1);
		req_valid <= 1'h0;
		lat = 0;
		do
		begin
			@(posedge aclk);
			lat++;
		end
		while (rsp_valid !== 1'h1);
	endtask
	task automatic dchk(input logic [23:0] a, input embd_mode_e m, input logic s,
		input embd_region_e g, input logic ill);
		acc(a, 1'h0, s, m);
		chk(rsp.illegal, ill);
		if (!ill)
			chk(rsp.region, g);
	endtask
	initial
	begin
		#200000;
		mismatches++;
		tally_and_finish();
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, req, req_valid} = '0;
		{sel11, page, stall, gpio_p37} = '0;
		s_axi_wstrb = 4'hf;
		external_access_select_n = 1'h1;
		gpio_p17 = 1'h1;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		chk(boot_internal, 1'h0);
		axr(12'h29c);
		chk(rd, 32'h0);
		axr(12'h100);
		chk(rr, 2'h2);
		axw(12'h100, 32'h0);
		chk(rr, 2'h2);
		axr(12'h2a4);
		chk(rd, 32'h28);
		axw(12'h29c, 32'h1);
		axr(12'h29c);
		chk(rd[7:0], 8'h01);
		axw(12'h29c, 32'h0);
		$display("registers done");
		cfg(16'h0002);
		@(posedge aclk);
		chk({p1_7_out, p3_7_out}, 2'h2);
		axw(12'h29c, 32'h2);
		prev = 1'h0;
		repeat (4)
		begin
			chk(p1_7_out, prev);
			prev = !prev;
			@(posedge aclk);
		end
		axw(12'h29c, 32'h0);
		$display("wait clock done");
		for (int s = 0; s < 3; s++)
		begin
			cfg(16'(s));
			acc(24'h0105a3, 1'h0, 1'h0, MD_INDIRECT);
			chk(cap, s == 0 ? 2'h1 : (s == 1 ? 2'h3 : 2'h2));
			chk(ps_seen, 1'h1);
			chk(rsp.rdata, 8'ha6);
			chk(oe_cap, 2'h1);
			acc(24'h0105a3, 1'h1, 1'h0, MD_INDIRECT);
			chk(wr_seen, 1'h1);
		end
		cfg(16'h0003);
		sel11 <= 1'h1;
		acc(24'h000500, 1'h0, 1'h0, MD_DIRECT);
		chk({ps_seen, rd_seen}, 2'h1);
		acc(24'hfe0100, 1'h0, 1'h0, MD_INDIRECT);
		chk({ps_seen, rd_seen}, 2'h2);
		acc(24'h010500, 1'h1, 1'h0, MD_INDIRECT);
		chk(wr_seen, 1'h0);
		acc(24'h000500, 1'h1, 1'h0, MD_DIRECT);
		chk(wr_seen, 1'h1);
		sel11 <= 1'h0;
		page <= 1'h1;
		cfg(16'h0004);
		acc(24'h00c35a, 1'h0, 1'h0, MD_DIRECT);
		chk(rsp.rdata, 8'h99);
		chk(oe_cap, 2'h2);
		acc(24'h00c35a, 1'h1, 1'h0, MD_DIRECT);
		chk({oe_cap, wdat}, 10'h33c);
		page <= 1'h0;
		$display("strobes done");
		cfg(16'h0020);
		dchk(24'h000010, MD_REGISTER, 1'h0, RG_REGFILE, 1'h0);
		dchk(24'h000040, MD_BIT, 1'h0, RG_RAM, 1'h0);
		dchk(24'h000100, MD_BIT, 1'h0, RG_RAM, 1'h1);
		dchk(24'h000300, MD_DIRECT, 1'h0, RG_RSVD, 1'h0);
		dchk(24'h000500, MD_DIRECT, 1'h0, RG_EXT, 1'h0);
		dchk(24'h030000, MD_INDIRECT, 1'h0, RG_RSVD, 1'h0);
		chk({rsp.undefined, rsp.rdata}, 9'h100);
		dchk(24'h010000, MD_DIRECT, 1'h0, RG_EXT, 1'h1);
		dchk(24'hff2000, MD_INDIRECT, 1'h0, RG_CODE, 1'h0);
		dchk(24'hfffff8, MD_INDIRECT, 1'h0, RG_CFG, 1'h1);
		dchk(24'h00e100, MD_INDIRECT, 1'h0, RG_CODE, 1'h0);
		chk(rsp.addr, 24'hff2100);
		dchk(24'h0000a7, MD_DIRECT, 1'h1, RG_SFR, 1'h0);
		chk(boot_internal, 1'h1);
		cfg(16'h0060);
		dchk(24'h000300, MD_DIRECT, 1'h0, RG_RAM, 1'h0);
		cfg(16'h0018);
		dchk(24'hff2000, MD_INDIRECT, 1'h0, RG_EXT, 1'h0);
		dchk(24'h00e100, MD_INDIRECT, 1'h0, RG_EXT, 1'h0);
		$display("decode done");
		cfg(16'h0100);
		stall <= 8'h03;
		acc(24'h000500, 1'h0, 1'h0, MD_DIRECT);
		chk(lat, 4);
		cfg(16'h0000);
		axw(12'h29c, 32'h1);
		acc(24'h000500, 1'h0, 1'h0, MD_DIRECT);
		chk(lat, 6);
		chk(rsp.rdata, 8'h05);
		$display("wait input done");
		cfg(16'h0006);
		aresetn <= 1'h0;
		repeat (64) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk(req_ready, 1'h0);
		@(posedge aclk);
		axr(12'h2a0);
		chk(rd, 32'h0);
		axr(12'h29c);
		chk(rd, 32'h0);
		$display("reset done");
		tally_and_finish();
	end
endmodule
